// ===== verilog/fbup_core.sv
// Purpose: Reads the palette area and the packed pixels of each frame and
//          delivers palette colours or direct pixels downstream.
// Assumes: Frame half-words arrive from the DMA side on ref_clk, low byte first.
// Notes:   Input and output hand-shakes are registered; input runs at half rate.
//
// How it works
// R01: Palette entries lead the frame; pixels follow at 0x200 or 0x20.
// R02: Bits 14..12 of entry zero pick the depth for the coming frame.
// R03: Codes 001, 010, 011 give 2, 4, 8 bits; 1xx gives direct pixels.
// R04: Palette addressing uses 4 bits for small depths, 8 bits for 8-bit pixels.
// R05: Four pixels per byte at 2 bits, two at 4; 12-bit right-justified.
// R06: Lowest pixel in the high bits; lower byte address comes first.
// R07: Depth, size or mode disagreeing with the DMA extent raises a sync event.
// R08: Software programs the DMA size from the depth and the pixel count.
// R09: Each encoded pixel indexes the palette directly.
// R10: The chosen entry goes to dithering: RGB fields, or one mono field.
// R11: Each 4-bit component is one of 16 levels.
// R12: Direct pixels on a passive display go straight to dithering.
// R13: Direct pixels on an active display go as 12 bits to the output FIFO.
// R14: With default loading, the palette is loaded before any pixel is used.
// R15: Software zero-fills the short palette area in direct modes.
// R16: Entries are 16 bits: spare bit, depth code in entry zero, intensity below.
// R17: A reserved depth code 000 keeps the previous frame's depth.

`timescale 1ns/1ps

module fbup_core #(
    parameter int DIM_W = 12
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic                  frame_start,
    input  wire fbup_pkg::fbup_cfg_t   cfg,
    input  wire logic [DIM_W-1:0]      line_len,
    input  wire logic [DIM_W-1:0]      line_count,
    input  wire logic [fbup_pkg::FBSIZE_W-1:0] dma_fb_bytes,
    input  wire logic                  word_valid,
    input  wire logic [15:0]           word_data,
    output logic                       word_ready,
    output logic                       dith_valid,
    output fbup_pkg::fbup_dith_t       dith_data,
    input  wire logic                  dith_ready,
    output logic                       ofifo_valid,
    output logic [11:0]                ofifo_data,
    input  wire logic                  ofifo_ready,
    output fbup_pkg::fbup_depth_t      pixel_depth,
    output logic                       frame_busy,
    output logic                       sync_err
);
    import fbup_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DIM_W < 1 || 2 * DIM_W > PIXCNT_W) begin : g_bad_dim
        $error("DIM_W must lie between 1 and half the pixel counter width");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fbup_state_t         state;
    fbup_state_t         next_state;
    fbup_depth_t         next_pixel_depth;
    logic [7:0]          entry;
    logic [7:0]          next_entry;
    logic [PIXCNT_W-1:0] pix_cnt;
    logic [PIXCNT_W-1:0] next_pix_cnt;
    logic                hold_full;
    logic                next_hold_full;
    logic [15:0]         hold_data;
    logic [15:0]         next_hold_data;
    logic                next_word_ready;
    logic                next_dith_valid;
    fbup_dith_t          next_dith_data;
    logic                next_ofifo_valid;
    logic [11:0]         next_ofifo_data;
    logic                next_frame_busy;
    logic                next_sync_err;

    logic [PIXCNT_W-1:0] pix_total;
    logic [2:0]          code;
    logic                pal_wr;
    logic                unp_flush;
    logic                unp_in_valid;
    logic                unp_in_ready;
    logic                unp_out_valid;
    logic [11:0]         unp_pix;
    logic                unp_out_ready;
    logic [11:0]         pal_data;
    logic                slot_free;
    logic                take;
    logic                frame_done;

    assign pix_total = PIXCNT_W'(line_len * line_count);
    assign code      = hold_data[CODE_MSB:CODE_LSB];                         // R16

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    fbup_unpack u_unpack (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .flush     (unp_flush),
        .depth     (pixel_depth),
        .in_valid  (unp_in_valid),
        .in_data   (hold_data),
        .in_ready  (unp_in_ready),
        .out_valid (unp_out_valid),
        .out_pix   (unp_pix),
        .out_ready (unp_out_ready)
    );

    fbup_palette u_palette (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .wr_en   (pal_wr),
        .wr_addr (entry),
        .wr_data (hold_data[COLOR_W-1:0]),
        .depth   (pixel_depth),
        .rd_addr (unp_pix[7:0]),
        .rd_data (pal_data)
    );

    // ------------------------------------------------------------
    // Frame sequencing and pixel delivery
    // ------------------------------------------------------------
    always_comb begin
        // Slot frees when both channels are empty or draining this cycle
        slot_free     = (!dith_valid || dith_ready) && (!ofifo_valid || ofifo_ready);
        frame_done    = (state == ST_PIX) && (pix_cnt == pix_total);
        take          = (state == ST_PIX) && unp_out_valid && slot_free && !frame_done;
        unp_out_ready = take;
        unp_in_valid  = (state == ST_PIX) && hold_full;                      // R14
        unp_flush     = frame_start || frame_done;
        pal_wr        = (state == ST_PAL) && hold_full && cfg.pal_load_en;   // R14

        next_state       = state;
        next_pixel_depth = pixel_depth;
        next_entry       = entry;
        next_pix_cnt     = pix_cnt;
        next_hold_full   = hold_full;
        next_hold_data   = hold_data;
        next_sync_err    = 1'b0;
        next_dith_valid  = dith_valid && !dith_ready;
        next_dith_data   = dith_data;
        next_ofifo_valid = ofifo_valid && !ofifo_ready;
        next_ofifo_data  = ofifo_data;

        // Consumption of the held half-word
        if (state == ST_PAL && hold_full) begin
            next_hold_full = 1'b0;
            if (entry == 8'h0) begin
                if (code != CODE_RESERVED) begin
                    next_pixel_depth = decode_depth(code);                   // R02 R03 R17
                end
                if (expected_size(next_pixel_depth, pix_total) != dma_fb_bytes
                    || (!cfg.color_mode && next_pixel_depth == DEPTH_16)) begin
                    next_sync_err = 1'b1;                                    // R07
                end
            end
            if (entry == pal_last(next_pixel_depth)) begin
                next_state = ST_PIX;                                         // R01
                next_entry = 8'h0;
            end else begin
                next_entry = entry + 8'h1;                                   // R01
            end
        end else if (unp_in_valid && unp_in_ready) begin
            next_hold_full = 1'b0;
        end

        if (word_ready && word_valid) begin
            next_hold_full = 1'b1;
            next_hold_data = word_data;
        end

        // Pixel routing
        if (take) begin
            next_pix_cnt = pix_cnt + PIXCNT_W'(1);
            if (pixel_depth == DEPTH_16 && cfg.active_mode) begin
                next_ofifo_valid = 1'b1;                                     // R13
                next_ofifo_data  = unp_pix;
            end else begin
                next_dith_valid      = 1'b1;
                next_dith_data.mono  = !cfg.color_mode;                      // R10
                if (pixel_depth == DEPTH_16) begin
                    next_dith_data.red   = unp_pix[11:8];                    // R12
                    next_dith_data.green = unp_pix[7:4];
                    next_dith_data.blue  = unp_pix[3:0];
                end else begin
                    next_dith_data.red   = pal_data[11:8];                   // R10 R11
                    next_dith_data.green = pal_data[7:4];                    // R10 R11
                    next_dith_data.blue  = pal_data[3:0];                    // R10 R11
                end
            end
        end

        if (frame_done) begin
            next_state     = ST_IDLE;
            next_hold_full = 1'b0;
        end

        // A new frame always restarts at palette entry zero
        if (frame_start) begin
            next_state     = ST_PAL;                                         // R14
            next_entry     = 8'h0;
            next_pix_cnt   = '0;
            next_hold_full = 1'b0;
        end

        next_frame_busy = (next_state != ST_IDLE);
        next_word_ready = (next_state != ST_IDLE) && !next_hold_full;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= ST_IDLE;
            pixel_depth <= DEPTH_RESET;
            entry       <= 8'h0;
            pix_cnt     <= '0;
            hold_full   <= 1'b0;
            hold_data   <= 16'h0;
            word_ready  <= 1'b0;
            dith_valid  <= 1'b0;
            dith_data   <= '0;
            ofifo_valid <= 1'b0;
            ofifo_data  <= 12'h0;
            frame_busy  <= 1'b0;
            sync_err    <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            pixel_depth <= next_pixel_depth;
            entry       <= next_entry;
            pix_cnt     <= next_pix_cnt;
            hold_full   <= next_hold_full;
            hold_data   <= next_hold_data;
            word_ready  <= next_word_ready;
            dith_valid  <= next_dith_valid;
            dith_data   <= next_dith_data;
            ofifo_valid <= next_ofifo_valid;
            ofifo_data  <= next_ofifo_data;
            frame_busy  <= next_frame_busy;
            sync_err    <= next_sync_err;
        end
    end

endmodule

// ===== verilog/fbup_pkg.sv
// Purpose: Shared constants, types and helpers of the frame buffer unpack and palette path.
// Assumes: One clock domain; the frame stream arrives as little-endian half-words.
// Notes:   Every figure of the frame buffer layout lives here once.

package fbup_pkg;

    // ------------------------------------------------------------
    // Frame buffer layout
    // ------------------------------------------------------------
    localparam logic [9:0]  PIX_OFS_LARGE  = 10'h200;   // Pixel data after 256 entries
    localparam logic [9:0]  PIX_OFS_SMALL  = 10'h020;   // Pixel data after 16 entries
    localparam int          ENTRY_BYTES    = 2;
    localparam int          CODE_MSB       = 14;
    localparam int          CODE_LSB       = 12;
    localparam int          COLOR_W        = 12;
    localparam logic [7:0]  PAL_LAST_SMALL = 8'h0f;
    localparam logic [7:0]  PAL_LAST_LARGE = 8'hff;
    localparam logic [2:0]  CODE_RESERVED  = 3'h0;
    localparam logic [2:0]  CODE_2BPP      = 3'h1;
    localparam logic [2:0]  CODE_4BPP      = 3'h2;
    localparam logic [2:0]  CODE_8BPP      = 3'h3;
    localparam int          PIXCNT_W       = 24;
    localparam int          FBSIZE_W       = 26;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEPTH_2  = 2'b00,
        DEPTH_4  = 2'b01,
        DEPTH_8  = 2'b10,
        DEPTH_16 = 2'b11
    } fbup_depth_t;

    localparam fbup_depth_t DEPTH_RESET = DEPTH_2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PAL  = 2'b01,
        ST_PIX  = 2'b10
    } fbup_state_t;

    typedef struct packed {
        logic color_mode;       // 1 colour, 0 monochrome
        logic active_mode;      // 1 active display
        logic pal_load_en;      // Default palette loading in force
    } fbup_cfg_t;

    typedef struct packed {
        logic       mono;
        logic [3:0] red;        // Unused in monochrome
        logic [3:0] green;      // Unused in monochrome
        logic [3:0] blue;       // Monochrome intensity in monochrome
    } fbup_dith_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic fbup_depth_t decode_depth(input logic [2:0] code);
        if (code[2]) begin
            decode_depth = DEPTH_16;
        end else if (code == CODE_8BPP) begin
            decode_depth = DEPTH_8;
        end else if (code == CODE_4BPP) begin
            decode_depth = DEPTH_4;
        end else begin
            decode_depth = DEPTH_2;
        end
    endfunction

    function automatic logic [7:0] pal_last(input fbup_depth_t d);
        pal_last = (d == DEPTH_8) ? PAL_LAST_LARGE : PAL_LAST_SMALL;
    endfunction

    function automatic logic [FBSIZE_W-1:0] expected_size(input fbup_depth_t d,
                                                         input logic [PIXCNT_W-1:0] n);
        logic [FBSIZE_W-1:0] pix;
        pix = {{(FBSIZE_W-PIXCNT_W){1'b0}}, n};
        case (d)
            DEPTH_2:  expected_size = {16'h0, PIX_OFS_SMALL} + (pix >> 2);
            DEPTH_4:  expected_size = {16'h0, PIX_OFS_SMALL} + (pix >> 1);
            DEPTH_8:  expected_size = {16'h0, PIX_OFS_LARGE} + pix;
            default:  expected_size = {16'h0, PIX_OFS_SMALL} + (pix << 1);
        endcase
    endfunction

endpackage

// ===== verilog/fbup_unpack.sv
// Purpose: Splits one little-endian frame half-word into its encoded pixels.
// Assumes: Depth is stable while a frame is unpacked.
// Notes:   Lower byte address first, and within a byte the high bits first.

`timescale 1ns/1ps

module fbup_unpack (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    input  wire logic                 flush,
    input  wire fbup_pkg::fbup_depth_t depth,
    input  wire logic                 in_valid,
    input  wire logic [15:0]          in_data,
    output logic                      in_ready,
    output logic                      out_valid,
    output logic [11:0]               out_pix,
    input  wire logic                 out_ready
);
    import fbup_pkg::*;

    logic [15:0] word;
    logic [2:0]  idx;
    logic        full;
    logic [15:0] next_word;
    logic [2:0]  next_idx;
    logic        next_full;
    logic [2:0]  last_idx;

    function automatic logic [11:0] extract(input logic [15:0] w, input fbup_depth_t d,
                                            input logic [2:0] k);
        logic [15:0] seq;
        logic [15:0] sh;
        seq = {w[7:0], w[15:8]};
        sh  = 16'h0;
        case (d)
            DEPTH_2: begin
                sh = seq << {k, 1'b0};
                extract = {10'h0, sh[15:14]};
            end
            DEPTH_4: begin
                sh = seq << {k[1:0], 2'b00};
                extract = {8'h0, sh[15:12]};
            end
            DEPTH_8: begin
                extract = {4'h0, k[0] ? w[15:8] : w[7:0]};
            end
            default: begin
                extract = w[11:0];
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pixel stepping
    // ------------------------------------------------------------
    always_comb begin
        case (depth)
            DEPTH_2: last_idx = 3'h7;          // R05
            DEPTH_4: last_idx = 3'h3;
            DEPTH_8: last_idx = 3'h1;
            default: last_idx = 3'h0;          // R05
        endcase
        in_ready  = !full || (out_ready && idx == last_idx);
        out_valid = full;
        out_pix   = extract(word, depth, idx); // R06
        next_word = word;
        next_idx  = idx;
        next_full = full;
        if (flush) begin
            next_full = 1'b0;
            next_idx  = 3'h0;
        end else if (full && out_ready && idx != last_idx) begin
            next_idx = idx + 3'h1;
        end else if (in_ready && in_valid) begin
            next_word = in_data;
            next_idx  = 3'h0;
            next_full = 1'b1;
        end else if (full && out_ready) begin
            next_full = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            word <= 16'h0;
            idx  <= 3'h0;
            full <= 1'b0;
        end else if (clk_en) begin
            word <= next_word;
            idx  <= next_idx;
            full <= next_full;
        end
    end

endmodule

// ===== verilog/fbup_palette.sv
// Purpose: Lookup palette of 256 entries, read without latency.
// Assumes: Writes come only while the palette area of a frame streams in.
// Notes:   Contents are not reset; software supplies them every frame.

`timescale 1ns/1ps

module fbup_palette (
    input  wire logic                  ref_clk,
    input  wire logic                  clk_en,
    input  wire logic                  wr_en,
    input  wire logic [7:0]            wr_addr,
    input  wire logic [11:0]           wr_data,
    input  wire fbup_pkg::fbup_depth_t depth,
    input  wire logic [7:0]            rd_addr,
    output logic [11:0]                rd_data
);
    import fbup_pkg::*;

    logic [11:0] mem [256];
    logic [7:0]  addr;

    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    always_comb begin
        // Small palettes see only four address bits
        addr    = (depth == DEPTH_8) ? rd_addr : {4'h0, rd_addr[3:0]}; // R04
        rd_data = mem[addr];                                             // R09
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule

// ===== sim/fbup_core_chk.sv
// Purpose: Port-level checks of the frame unpack and palette core.
// Assumes: cfg is held steady while a frame runs; clk_en high.
// Notes:   Bound from the bench top file.

`timescale 1ns/1ps

module fbup_core_chk (
    input wire logic                  ref_clk,
    input wire logic                  resetn,
    input wire logic                  clk_en,
    input wire logic                  frame_start,
    input wire fbup_pkg::fbup_cfg_t   cfg,
    input wire logic                  word_valid,
    input wire logic                  word_ready,
    input wire logic                  dith_valid,
    input wire fbup_pkg::fbup_dith_t  dith_data,
    input wire logic                  dith_ready,
    input wire logic                  ofifo_valid,
    input wire logic [11:0]           ofifo_data,
    input wire logic                  ofifo_ready,
    input wire fbup_pkg::fbup_depth_t pixel_depth,
    input wire logic                  frame_busy,
    input wire logic                  sync_err
);
    import fbup_pkg::*;

    wire logic take = word_valid && word_ready && clk_en;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    dith_hold_a: assert property (dith_valid && !dith_ready |=>
        dith_valid && $stable(dith_data)) else $error("dither pixel changed before taken");
    ofifo_hold_a: assert property (ofifo_valid && !ofifo_ready |=>
        ofifo_valid && $stable(ofifo_data)) else $error("direct pixel changed before taken");
    word_gap_a: assert property (take |=> !word_ready)
        else $error("half-word ready again right after a take");
    idle_ready_a: assert property (!frame_busy |-> !word_ready)
        else $error("half-word ready outside a frame");
    start_ready_a: assert property (frame_start && clk_en |=> word_ready && frame_busy)
        else $error("frame start did not open the palette fetch");
    ofifo_route_a: assert property (
        ofifo_valid |-> pixel_depth == DEPTH_16 && cfg.active_mode)
        else $error("output FIFO fed outside active direct mode");
    dith_route_a: assert property (
        dith_valid && pixel_depth == DEPTH_16 |-> !cfg.active_mode)
        else $error("direct pixel sent to dither in active mode");
    one_lane_a: assert property (!(dith_valid && ofifo_valid))
        else $error("both pixel outputs valid at once");
    mono_flag_a: assert property (dith_valid |-> dith_data.mono == !cfg.color_mode)
        else $error("mono flag disagrees with the display mode");
    sync_pulse_a: assert property (sync_err |=> !sync_err)
        else $error("sync event longer than one cycle");
    sync_cause_a: assert property (sync_err |-> $past(take, 2) || $past(take, 3))
        else $error("sync event without a half-word just taken");

    dith_cov_c: cover property (dith_valid && dith_ready);
    ofifo_cov_c: cover property (ofifo_valid && ofifo_ready);
    sync_cov_c: cover property (sync_err);
endmodule

// ===== sim/fbup_dma.sv
// Purpose: Behavioural DMA side that streams one frame buffer.
// Assumes: Bench calls fetch once per frame start.
// Notes:   Released data shows the inverse of the last half-word.

`timescale 1ns/1ps

module fbup_dma (
    input  wire logic        ref_clk,
    input  wire logic        word_ready,
    output logic             word_valid,
    output logic [15:0]      word_data
);
    initial begin
        word_valid = 1'b0;
        word_data  = 16'hffff;
    end

    function automatic logic [11:0] col(input int e);
        col = 12'(e * 149 + 7);
    endfunction

    // First pixel is 255 masked to the pixel width, so at 4 and 8 bits it hits the last palette entry
    function automatic logic [11:0] pix(input int i, input int bits);
        pix = 12'((255 - 5 * i) & ((1 << bits) - 1));
    endfunction

    task automatic send(input logic [15:0] w, input int gap);
        repeat (gap) @(posedge ref_clk);
        word_valid <= 1'b1;
        word_data  <= w;
        do @(posedge ref_clk); while (word_ready !== 1'b1);
        word_valid <= 1'b0;
        word_data  <= ~w;
    endtask

    task automatic fetch(input logic [2:0] code, input int nent, input int bits,
                         input int n, input int gap);
        logic [15:0] w;
        int          k;
        int          per;
        for (int e = 0; e < nent; e++) begin
            w = (bits == 12) ? 16'h0 : {4'h0, col(e)};
            if (e == 0) w[14:12] = code;
            send(w, gap);
        end
        k   = (bits == 12) ? 1 : 16 / bits;
        per = (bits == 12) ? 1 : 8 / bits;
        for (int i = 0; i < n; i += k) begin
            w = (bits == 12) ? {4'hc, pix(i, 12)} : 16'h0;
            for (int j = 0; j < k && bits != 12; j++) begin
                w |= 16'(pix(i + j, bits)) << ((j / per) * 8 + 8 - bits * (j % per + 1));
            end
            send(w, gap);
        end
    endtask
endmodule

// ===== sim/fbup_core_bench.sv
// Purpose: Self-checking bench of the frame unpack and palette core.
// Assumes: One frame at a time; cfg steady during a frame.
// Notes:   Frame size is programmed per depth, optionally off by one.

`timescale 1ns/1ps

module fbup_core_bench;
    import fbup_pkg::*;

    logic              ref_clk;
    logic              resetn;
    logic              clk_en;
    logic              frame_start;
    fbup_cfg_t         cfg;
    logic [11:0]       line_len;
    logic [11:0]       line_count;
    logic [FBSIZE_W-1:0] dma_fb_bytes;
    logic              word_valid;
    logic [15:0]       word_data;
    logic              word_ready;
    logic              dith_valid;
    fbup_dith_t        dith_data;
    logic              dith_ready;
    logic              ofifo_valid;
    logic [11:0]       ofifo_data;
    logic              ofifo_ready;
    fbup_depth_t       pixel_depth;
    logic              frame_busy;
    logic              sync_err;
    int                err_total;
    int                n_tests;

    fbup_core dut (.*);

    fbup_dma dma (.*);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // One frame: fetch, collect, compare
    // ------------------------------------------------------------
    task automatic frame(input logic [2:0] code, input fbup_depth_t d, input int bits,
                         input int nent, input int n, input int gap, input logic st,
                         input int fbd, input int xs);
        logic [15:0] q[$];
        logic [15:0] e;
        logic [15:0] m;
        int          syncs;
        int          sz;
        syncs = 0;
        sz = (bits == 2) ? 32 + n / 4 : (bits == 4) ? 32 + n / 2 :
             (bits == 8) ? 512 + n : 32 + 2 * n;
        line_len     <= 12'(n / 2);
        line_count   <= 12'h2;
        dma_fb_bytes <= 26'(sz + fbd);
        @(posedge ref_clk);
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        fork
            dma.fetch(code, nent, bits, n, gap);
            while (q.size() < n) begin
                @(posedge ref_clk);
                if (sync_err === 1'b1) syncs++;
                if (dith_valid === 1'b1 && dith_ready === 1'b1) q.push_back({3'h0, dith_data});
                if (ofifo_valid === 1'b1 && ofifo_ready === 1'b1) q.push_back({4'h0, ofifo_data});
                dith_ready  <= st ? ~dith_ready : 1'b1;
                ofifo_ready <= st ? ~ofifo_ready : 1'b1;
            end
        join
        repeat (3) @(posedge ref_clk);
        m = cfg.color_mode ? 16'hffff : 16'h100f;
        for (int i = 0; i < n; i++) begin
            e = {3'h0, ~cfg.color_mode, (bits == 12) ? dma.pix(i, 12) : dma.col(dma.pix(i, bits))};
            if (bits == 12 && cfg.active_mode) e = {4'h0, dma.pix(i, 12)};
            chk(q[i] & m, e & m);
        end
        chk({14'h0, pixel_depth}, {14'h0, d});
        chk({15'h0, frame_busy}, 16'h0);
        chk(16'(syncs), 16'(xs));
    endtask

    task automatic t_two_bit; cfg <= 3'b101; frame(3'h1, DEPTH_2, 2, 16, 6, 1, 0, 0, 0); endtask
    task automatic t_four_mono; cfg <= 3'b001; frame(3'h2, DEPTH_4, 4, 16, 8, 3, 1, 0, 0); endtask
    task automatic t_eight; cfg <= 3'b101; frame(3'h3, DEPTH_8, 8, 256, 10, 1, 0, 0, 0); endtask
    task automatic t_reserved; cfg <= 3'b101; frame(3'h0, DEPTH_8, 8, 256, 6, 1, 0, 0, 0); endtask
    task automatic t_direct_pas; cfg <= 3'b101; frame(3'h4, DEPTH_16, 12, 16, 4, 1, 1, 0, 0); endtask
    task automatic t_direct_act; cfg <= 3'b111; frame(3'h6, DEPTH_16, 12, 16, 4, 1, 1, 0, 0); endtask
    task automatic t_size_bad; cfg <= 3'b101; frame(3'h2, DEPTH_4, 4, 16, 4, 1, 0, 1, 1); endtask
    task automatic t_mono_direct; cfg <= 3'b001; frame(3'h7, DEPTH_16, 12, 16, 4, 1, 0, 0, 1); endtask

    initial begin
        err_total    = 0;
        n_tests      = 0;
        resetn       = 1'b0;
        clk_en       = 1'b1;
        frame_start  = 1'b0;
        cfg          = 3'b000;
        line_len     = 12'h0;
        line_count   = 12'h0;
        dma_fb_bytes = 26'h0;
        dith_ready   = 1'b1;
        ofifo_ready  = 1'b1;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_two_bit();
        t_four_mono();
        t_eight();
        t_reserved();
        t_direct_pas();
        t_direct_act();
        t_size_bad();
        t_mono_direct();
        results();
    end

    // Whole run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        results();
    end
endmodule

bind fbup_core fbup_core_chk chk (.*);
